// ### ost_osc_ctrl.sv
// Oscillator select, RC trim and supply sampling control top
//
// Notes on behaviour
// - Programming enable bit is active low
// - Programming enabled starts the fast internal RC
// - Low power sampling only counts when detecting
// - Normal mode compares supply continuously
// - Low power mode samples once per interval
// - No hysteresis in low power sampling
// - Gain bit low selects half amplifier gain
// - Dedicated bit enables crystal input filter
// - Source bit zero runs the internal RC
// - Speed bit zero uses divide-by-two path
// - Trim writes need the timed access window
// - Six bit trim, zero fastest, midpoint untrimmed
// - Trim starts from factory setting
// - Source bit one selects crystal or clock
// - Speed bit one bypasses the divider
`timescale 1ns/100ps
`default_nettype none
module ost_osc_ctrl #(
	parameter int SAMPLE_INTERVAL = ost_pkg::INTERVAL_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic [7:0]      sfr_rdata,
	output logic            sfr_hit,
	input  wire logic       timed_access_open,
	input  wire logic       cfg_clock_source_select,
	input  wire logic       cfg_internal_rc_speed_select,
	input  wire logic       cfg_crystal_gain_reduce,
	input  wire logic       cfg_xtal_input_filter_enable,
	input  wire logic       cfg_supply_drop_detect_enable,
	input  wire logic [5:0] factory_trim,
	input  wire logic       supply_below,
	output logic [5:0]      rc_trim_value,
	output logic            in_system_programming,
	output logic            rc_osc_enable,
	output logic            rc_div2_select,
	output logic            sys_clk_from_xtal,
	output logic            xtal_amp_enable,
	output logic            xtal_gain_half,
	output logic            xtal_filter_enable,
	output logic            comparator_enable,
	output logic            slow_rc_enable,
	output logic            hysteresis_enable,
	output logic            sample_strobe,
	output logic            supply_low
);
	typedef struct packed {
		logic       loaded;
		logic [5:0] trim;
		logic       program_update_enable;
		logic       supply_drop_detect_enable;
		logic       low_power_supply_sampling;
		logic [7:0] rdata;
	} ost_regs_t;

	ost_regs_t s;
	ost_regs_t next_s;
	logic      wr_ok;
	logic      wr_trim;
	logic      wr_chip;
	logic      wr_pmon;

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == ost_pkg::OFF_RC_TRIM) || (a == ost_pkg::OFF_CHIP_CTRL) ||
			(a == ost_pkg::OFF_PWR_MON);
	endfunction

	function automatic logic [7:0] read_value(input logic [7:0] a, input ost_regs_t r, input logic low);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ost_pkg::OFF_RC_TRIM: begin
				v[ost_pkg::TRIM_LSB +: ost_pkg::TRIM_W] = r.trim;
			end
			ost_pkg::OFF_CHIP_CTRL: begin
				v[ost_pkg::BIT_PROG_EN_N] = r.program_update_enable;
			end
			ost_pkg::OFF_PWR_MON: begin
				v[ost_pkg::BIT_DETECT_EN]  = r.supply_drop_detect_enable;
				v[ost_pkg::BIT_LP_SAMPLE]  = r.low_power_supply_sampling;
				v[ost_pkg::BIT_SUPPLY_LOW] = low;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	assign sfr_hit = is_mapped(sfr_addr);
	assign wr_ok   = sfr_wr && timed_access_open;
	assign wr_trim = wr_ok && (sfr_addr == ost_pkg::OFF_RC_TRIM);
	assign wr_chip = wr_ok && (sfr_addr == ost_pkg::OFF_CHIP_CTRL);
	assign wr_pmon = wr_ok && (sfr_addr == ost_pkg::OFF_PWR_MON);

	always_comb begin
		next_s = s;
		if (!s.loaded) begin
			// factory trim taken after reset release
			next_s.loaded                    = 1'b1;
			next_s.trim                      = factory_trim;
			next_s.supply_drop_detect_enable = cfg_supply_drop_detect_enable;
		end
		if (wr_trim) begin
			// trim occupies bits five to zero
			next_s.trim = sfr_wdata[ost_pkg::TRIM_LSB +: ost_pkg::TRIM_W];
		end
		if (wr_chip) begin
			next_s.program_update_enable = sfr_wdata[ost_pkg::BIT_PROG_EN_N];
		end
		if (wr_pmon) begin
			next_s.supply_drop_detect_enable = sfr_wdata[ost_pkg::BIT_DETECT_EN];
			next_s.low_power_supply_sampling = sfr_wdata[ost_pkg::BIT_LP_SAMPLE];
		end
		if (sfr_rd) begin
			next_s.rdata = read_value(sfr_addr, s, supply_low);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{loaded: 1'b0,
				trim: ost_pkg::TRIM_MIDPOINT,
				program_update_enable: ost_pkg::PROG_EN_N_RST,
				supply_drop_detect_enable: ost_pkg::DETECT_EN_RST,
				low_power_supply_sampling: ost_pkg::LP_SAMPLE_RST,
				rdata: ost_pkg::RDATA_RST};
		end else begin
			s <= next_s;
		end
	end

	assign sfr_rdata             = s.rdata;
	assign rc_trim_value         = s.trim;
	assign in_system_programming = !s.program_update_enable;

	ost_clk_route u_route (
		.ref_clk                  (ref_clk),
		.rst_n                    (rst_n),
		.clock_source_select      (cfg_clock_source_select),
		.internal_rc_speed_select (cfg_internal_rc_speed_select),
		.crystal_gain_reduce      (cfg_crystal_gain_reduce),
		.xtal_input_filter_enable (cfg_xtal_input_filter_enable),
		.program_update_enable    (s.program_update_enable),
		.rc_osc_enable            (rc_osc_enable),
		.rc_div2_select           (rc_div2_select),
		.sys_clk_from_xtal        (sys_clk_from_xtal),
		.xtal_amp_enable          (xtal_amp_enable),
		.xtal_gain_half           (xtal_gain_half),
		.xtal_filter_enable       (xtal_filter_enable)
	);

	ost_supply_sampler #(
		.INTERVAL (SAMPLE_INTERVAL),
		.LOOK_LEN (ost_pkg::LOOK_CYC)
	) u_sampler (
		.ref_clk           (ref_clk),
		.rst_n             (rst_n),
		.detect_enable     (s.supply_drop_detect_enable),
		.low_power         (s.low_power_supply_sampling),
		.supply_below      (supply_below),
		.comparator_enable (comparator_enable),
		.slow_rc_enable    (slow_rc_enable),
		.hysteresis_enable (hysteresis_enable),
		.sample_strobe     (sample_strobe),
		.supply_low        (supply_low)
	);

	// Helper: cycles since the last sample in steady low power mode
	localparam int GAP_W = $clog2(SAMPLE_INTERVAL + ost_pkg::LOOK_CYC + 2);
	localparam logic [GAP_W-1:0] GAP_PERIOD = GAP_W'(SAMPLE_INTERVAL + ost_pkg::LOOK_CYC);
	logic [GAP_W-1:0] gap;
	logic             gap_valid;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap       <= '0;
			gap_valid <= 1'b0;
		end else if (!(s.supply_drop_detect_enable && s.low_power_supply_sampling)) begin
			gap       <= '0;
			gap_valid <= 1'b0;
		end else if (sample_strobe) begin
			gap       <= GAP_W'(1);
			gap_valid <= 1'b1;
		end else if (gap != GAP_PERIOD) begin
			gap <= gap + GAP_W'(1);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence lp_steady;
		s.supply_drop_detect_enable && s.low_power_supply_sampling;
	endsequence

	sequence cont_steady;
		(s.supply_drop_detect_enable && !s.low_power_supply_sampling) [*2];
	endsequence

	sequence chip_write;
		wr_chip;
	endsequence

	prog_polarity_a: assert property (chip_write |=>
		(in_system_programming == !$past(sfr_wdata[ost_pkg::BIT_PROG_EN_N])))
		else $error("programming enable polarity wrong");

	prog_rc_start_a: assert property (in_system_programming && s.loaded |=> rc_osc_enable)
		else $error("RC not started while programming");

	lp_ignored_a: assert property (!s.supply_drop_detect_enable |=>
		(!slow_rc_enable && !comparator_enable && !supply_low))
		else $error("sampling active while detection off");

	cont_compare_a: assert property (cont_steady |->
		(comparator_enable && hysteresis_enable && !slow_rc_enable))
		else $error("comparison not continuous");

	sample_period_a: assert property (sample_strobe && gap_valid |-> gap == GAP_PERIOD)
		else $error("sample interval wrong");

	sample_value_a: assert property (sample_strobe |->
		(supply_low == $past(supply_below) && slow_rc_enable))
		else $error("sample not taken from comparator");

	no_hysteresis_a: assert property (lp_steady ##1 lp_steady |->
		(!hysteresis_enable && slow_rc_enable))
		else $error("hysteresis left on in low power mode");

	gain_filter_a: assert property (s.loaded |->
		(xtal_gain_half == !$past(cfg_crystal_gain_reduce) &&
		xtal_filter_enable == $past(cfg_xtal_input_filter_enable)))
		else $error("gain or filter steering wrong");

	source_sel_a: assert property (s.loaded |->
		(sys_clk_from_xtal == $past(cfg_clock_source_select) &&
		($past(cfg_clock_source_select) || rc_osc_enable)))
		else $error("clock source steering wrong");

	rc_divider_a: assert property (s.loaded |->
		(rc_div2_select == !$past(cfg_internal_rc_speed_select)))
		else $error("RC divider path wrong");

	trim_guard_a: assert property (s.loaded && !wr_trim |=> $stable(rc_trim_value))
		else $error("trim changed without timed access");

	trim_write_a: assert property (wr_trim |=>
		(rc_trim_value == $past(sfr_wdata[5:0])))
		else $error("trim write not stored");

	trim_load_a: assert property ($rose(s.loaded) && !$past(wr_trim) |->
		(rc_trim_value == $past(factory_trim)))
		else $error("trim not loaded from factory setting");

	sequence trim_read;
		sfr_rd && (sfr_addr == ost_pkg::OFF_RC_TRIM);
	endsequence

	sequence chip_read;
		sfr_rd && (sfr_addr == ost_pkg::OFF_CHIP_CTRL);
	endsequence

	trim_read_a: assert property (trim_read |=>
		(sfr_rdata == {2'b00, $past(rc_trim_value)}))
		else $error("trim read back wrong");

	prog_read_a: assert property (chip_read |=>
		(sfr_rdata == {7'h00, !$past(in_system_programming)}))
		else $error("programming enable read back wrong");

	isp_guard_a: assert property (!wr_chip |=> $stable(in_system_programming))
		else $error("programming enable changed without timed access");

	pmon_guard_a: assert property (s.loaded && !wr_pmon |=>
		$stable({s.supply_drop_detect_enable, s.low_power_supply_sampling}))
		else $error("power monitor bits changed without timed access");

	rc_stop_a: assert property (!in_system_programming && cfg_clock_source_select |=>
		!rc_osc_enable)
		else $error("RC left running after programming");

	low_hold_a: assert property (lp_steady ##1
		(s.supply_drop_detect_enable && s.low_power_supply_sampling && !sample_strobe) |-> $stable(supply_low))
		else $error("decision changed between samples");

	look_first_a: assert property (sample_strobe |-> $past(comparator_enable))
		else $error("sample taken without comparator window");

	amp_follow_a: assert property (s.loaded |->
		(xtal_amp_enable == $past(cfg_clock_source_select)))
		else $error("crystal amplifier steering wrong");
endmodule
`default_nettype wire

// ### ost_pkg.sv
// Shared constants for oscillator select and trim control
`default_nettype none
package ost_pkg;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam logic [7:0]  OFF_RC_TRIM    = 8'h97;
	localparam logic [7:0]  OFF_CHIP_CTRL  = 8'h9f;
	localparam logic [7:0]  OFF_PWR_MON    = 8'hac;
	localparam int          TRIM_W         = 6;
	localparam int          TRIM_LSB       = 0;
	localparam logic [5:0]  TRIM_MIDPOINT  = 6'h20;
	localparam int          BIT_PROG_EN_N  = 0;
	localparam logic        PROG_EN_N_RST  = 1'b1;
	localparam int          BIT_DETECT_EN  = 7;
	localparam int          BIT_LP_SAMPLE  = 2;
	localparam int          BIT_SUPPLY_LOW = 0;
	localparam logic        DETECT_EN_RST  = 1'b0;
	localparam logic        LP_SAMPLE_RST  = 1'b0;
	localparam logic [7:0]  RDATA_RST      = 8'h00;
	localparam int          INTERVAL_NS    = 12_800_000;
	localparam int          INTERVAL_CYC   = INTERVAL_NS / CLK_PERIOD_NS;
	localparam int          LOOK_NS        = 20;
	localparam int          LOOK_CYC       = (LOOK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### ost_clk_route.sv
// Registered clock source, divider and crystal amplifier steering
`timescale 1ns/100ps
`default_nettype none
module ost_clk_route (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic clock_source_select,
	input  wire logic internal_rc_speed_select,
	input  wire logic crystal_gain_reduce,
	input  wire logic xtal_input_filter_enable,
	input  wire logic program_update_enable,
	output logic      rc_osc_enable,
	output logic      rc_div2_select,
	output logic      sys_clk_from_xtal,
	output logic      xtal_amp_enable,
	output logic      xtal_gain_half,
	output logic      xtal_filter_enable
);
	typedef struct packed {
		logic rc_on;
		logic div2;
		logic xtal_sel;
		logic half_gain;
		logic filter;
	} ost_route_t;

	ost_route_t s;
	ost_route_t next_s;

	always_comb begin
		next_s.xtal_sel  = clock_source_select;
		next_s.rc_on     = !clock_source_select || !program_update_enable;
		next_s.div2      = !internal_rc_speed_select;
		next_s.half_gain = !crystal_gain_reduce;
		next_s.filter    = xtal_input_filter_enable;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rc_osc_enable      = s.rc_on;
	assign rc_div2_select     = s.div2;
	assign sys_clk_from_xtal  = s.xtal_sel;
	assign xtal_amp_enable    = s.xtal_sel;
	assign xtal_gain_half     = s.half_gain;
	assign xtal_filter_enable = s.filter;
endmodule
`default_nettype wire

// ### ost_supply_sampler.sv
// Supply comparison scheduler: continuous or interval sampling
`timescale 1ns/100ps
`default_nettype none
module ost_supply_sampler #(
	parameter int INTERVAL = ost_pkg::INTERVAL_CYC,
	parameter int LOOK_LEN = ost_pkg::LOOK_CYC
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic detect_enable,
	input  wire logic low_power,
	input  wire logic supply_below,
	output logic      comparator_enable,
	output logic      slow_rc_enable,
	output logic      hysteresis_enable,
	output logic      sample_strobe,
	output logic      supply_low
);
	localparam int CW = $clog2(INTERVAL + LOOK_LEN + 1);

	typedef enum logic [1:0] {SMP_OFF, SMP_CONT, SMP_WAIT, SMP_LOOK} ost_smp_mode_t;
	typedef struct packed {
		ost_smp_mode_t   mode;
		logic [CW-1:0]   cnt;
		logic            low;
		logic            strobe;
	} ost_smp_t;

	ost_smp_t s;
	ost_smp_t next_s;

	always_comb begin
		next_s = s;
		next_s.strobe = 1'b0;
		if (!detect_enable) begin
			next_s.mode = SMP_OFF;
			next_s.cnt  = '0;
			next_s.low  = 1'b0;
		end else if (!low_power) begin
			next_s.mode = SMP_CONT;
			next_s.cnt  = '0;
			next_s.low  = supply_below;
		end else begin
			case (s.mode)
				SMP_WAIT: begin
					if (s.cnt == CW'(INTERVAL - 1)) begin
						next_s.mode = SMP_LOOK;
						next_s.cnt  = '0;
					end else begin
						next_s.cnt = s.cnt + CW'(1);
					end
				end
				SMP_LOOK: begin
					if (s.cnt == CW'(LOOK_LEN - 1)) begin
						next_s.low    = supply_below;
						next_s.strobe = 1'b1;
						next_s.mode   = SMP_WAIT;
						next_s.cnt    = '0;
					end else begin
						next_s.cnt = s.cnt + CW'(1);
					end
				end
				default: begin
					next_s.mode = SMP_WAIT;
					next_s.cnt  = '0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{mode: SMP_OFF, cnt: '0, low: 1'b0, strobe: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign comparator_enable = (s.mode == SMP_CONT) || (s.mode == SMP_LOOK);
	assign slow_rc_enable    = (s.mode == SMP_WAIT) || (s.mode == SMP_LOOK);
	assign hysteresis_enable = (s.mode == SMP_CONT);
	assign sample_strobe     = s.strobe;
	assign supply_low        = s.low;
endmodule
`default_nettype wire

// ### ost_osc_ctrl_tb.sv
// Self-checking bench for oscillator select, trim and supply sampling control
`timescale 1ns/100ps
`default_nettype none
module ost_osc_ctrl_tb;
	localparam int INTV = 4;
	logic       ref_clk;
	logic       rst_n;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       sfr_hit;
	logic       timed_access_open;
	logic       cfg_src;
	logic       cfg_speed;
	logic       cfg_gain;
	logic       cfg_filt;
	logic       cfg_det;
	logic [5:0] factory_trim;
	logic       supply_below;
	logic [5:0] rc_trim_value;
	logic       in_system_programming;
	logic       rc_osc_enable;
	logic       rc_div2_select;
	logic       sys_clk_from_xtal;
	logic       xtal_amp_enable;
	logic       xtal_gain_half;
	logic       xtal_filter_enable;
	logic       comparator_enable;
	logic       slow_rc_enable;
	logic       hysteresis_enable;
	logic       sample_strobe;
	logic       supply_low;
	int         miscompares;
	int         tests_run;
	logic [7:0] rd_val;
	int         gap;

	ost_osc_ctrl #(.SAMPLE_INTERVAL(INTV)) uut (
		.ref_clk                      (ref_clk),
		.rst_n                        (rst_n),
		.sfr_addr                     (sfr_addr),
		.sfr_wr                       (sfr_wr),
		.sfr_rd                       (sfr_rd),
		.sfr_wdata                    (sfr_wdata),
		.sfr_rdata                    (sfr_rdata),
		.sfr_hit                      (sfr_hit),
		.timed_access_open            (timed_access_open),
		.cfg_clock_source_select      (cfg_src),
		.cfg_internal_rc_speed_select (cfg_speed),
		.cfg_crystal_gain_reduce      (cfg_gain),
		.cfg_xtal_input_filter_enable (cfg_filt),
		.cfg_supply_drop_detect_enable(cfg_det),
		.factory_trim                 (factory_trim),
		.supply_below                 (supply_below),
		.rc_trim_value                (rc_trim_value),
		.in_system_programming        (in_system_programming),
		.rc_osc_enable                (rc_osc_enable),
		.rc_div2_select               (rc_div2_select),
		.sys_clk_from_xtal            (sys_clk_from_xtal),
		.xtal_amp_enable              (xtal_amp_enable),
		.xtal_gain_half               (xtal_gain_half),
		.xtal_filter_enable           (xtal_filter_enable),
		.comparator_enable            (comparator_enable),
		.slow_rc_enable               (slow_rc_enable),
		.hysteresis_enable            (hysteresis_enable),
		.sample_strobe                (sample_strobe),
		.supply_low                   (supply_low)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Write taken at the edge that sees the strobe; clock routing and sampler outputs settle one edge later
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		timed_access_open <= ta;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		timed_access_open <= 1'b0;
		cycles(2);
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic hit, output logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		#1;
		chk({7'h00, sfr_hit}, {7'h00, hit});
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		cycles(1);
		d = sfr_rdata;
	endtask

	task automatic wait_strobe();
		int n;
		n = 0;
		while (sample_strobe !== 1'b1) begin
			cycles(1);
			n++;
			if (n > 50) begin
				miscompares++;
				$display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
				wrap_up();
			end
		end
	endtask

	initial begin
		miscompares = 0;
		tests_run = 0;
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		timed_access_open = 1'b0;
		{cfg_src, cfg_speed, cfg_gain, cfg_filt, cfg_det} = 5'h1c;
		factory_trim = 6'h2b;
		supply_below = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		cycles(3);
		// Trim from factory value
		chk({2'h0, rc_trim_value}, 8'h2b);
		reg_rd(ost_pkg::OFF_RC_TRIM, 1'b1, rd_val);
		chk(rd_val, 8'h2b);
		$display("test reset values done");

		// Protected trim writes
		reg_wr(ost_pkg::OFF_RC_TRIM, 8'h05, 1'b0);
		chk({2'h0, rc_trim_value}, 8'h2b);
		reg_wr(ost_pkg::OFF_RC_TRIM, 8'hff, 1'b1);
		chk({2'h0, rc_trim_value}, 8'h3f);
		reg_rd(ost_pkg::OFF_RC_TRIM, 1'b1, rd_val);
		chk(rd_val, 8'h3f);
		reg_wr(ost_pkg::OFF_RC_TRIM, 8'h00, 1'b1);
		chk({2'h0, rc_trim_value}, 8'h00);
		reg_wr(ost_pkg::OFF_RC_TRIM, {2'h0, ost_pkg::TRIM_MIDPOINT}, 1'b1);
		chk({2'h0, rc_trim_value}, 8'h20);
		reg_rd(8'h50, 1'b0, rd_val);
		chk(rd_val, 8'h00);
		$display("test trim access done");

		// Programming enable, crystal source selected
		reg_wr(ost_pkg::OFF_CHIP_CTRL, 8'h01, 1'b0);
		chk({7'h00, rc_osc_enable}, 8'h00);
		reg_wr(ost_pkg::OFF_CHIP_CTRL, 8'h00, 1'b0);
		chk({7'h00, in_system_programming}, 8'h00);
		reg_wr(ost_pkg::OFF_CHIP_CTRL, 8'h00, 1'b1);
		chk({7'h00, in_system_programming}, 8'h01);
		chk({7'h00, rc_osc_enable}, 8'h01);
		reg_rd(ost_pkg::OFF_CHIP_CTRL, 1'b1, rd_val);
		chk(rd_val, 8'h00);
		// Session ends by disabling programming
		reg_wr(ost_pkg::OFF_CHIP_CTRL, 8'h01, 1'b1);
		chk({7'h00, in_system_programming}, 8'h00);
		chk({7'h00, rc_osc_enable}, 8'h00);
		$display("test programming enable done");

		// Every source, speed, gain and filter setting
		for (int i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			{cfg_src, cfg_speed, cfg_gain, cfg_filt} <= 4'(i);
			cycles(3);
			chk({7'h00, sys_clk_from_xtal}, {7'h00, cfg_src});
			chk({7'h00, xtal_amp_enable}, {7'h00, cfg_src});
			chk({7'h00, rc_osc_enable}, {7'h00, ~cfg_src});
			if (!cfg_src) begin
				chk({7'h00, rc_div2_select}, {7'h00, ~cfg_speed});
			end
			chk({7'h00, xtal_gain_half}, {7'h00, ~cfg_gain});
			chk({7'h00, xtal_filter_enable}, {7'h00, cfg_filt});
		end
		$display("test clock routing done");

		// Low power bit alone does nothing
		reg_wr(ost_pkg::OFF_PWR_MON, 8'h84, 1'b0);
		reg_wr(ost_pkg::OFF_PWR_MON, 8'h04, 1'b1);
		cycles(2 * INTV);
		chk({6'h00, slow_rc_enable, comparator_enable}, 8'h00);
		chk({7'h00, supply_low}, 8'h00);

		// Continuous comparison
		reg_wr(ost_pkg::OFF_PWR_MON, 8'h80, 1'b1);
		cycles(2);
		chk({5'h00, comparator_enable, hysteresis_enable, slow_rc_enable}, 8'h06);
		chk({7'h00, supply_low}, 8'h01);
		reg_rd(ost_pkg::OFF_PWR_MON, 1'b1, rd_val);
		chk(rd_val, 8'h81);
		@(posedge ref_clk);
		supply_below <= 1'b0;
		cycles(2);
		chk({7'h00, supply_low}, 8'h00);
		$display("test continuous detection done");

		// Interval sampling
		@(posedge ref_clk);
		supply_below <= 1'b1;
		reg_wr(ost_pkg::OFF_PWR_MON, 8'h84, 1'b1);
		chk({6'h00, slow_rc_enable, hysteresis_enable}, 8'h02);
		wait_strobe();
		chk({7'h00, supply_low}, 8'h01);
		@(posedge ref_clk);
		supply_below <= 1'b0;
		cycles(1);
		// Two edges have passed since the strobe
		gap = 2;
		while (sample_strobe !== 1'b1 && gap < 50) begin
			chk({7'h00, supply_low}, 8'h01);
			cycles(1);
			gap++;
		end
		chk(8'(gap), 8'(INTV + 2));
		chk({7'h00, supply_low}, 8'h00);
		$display("test interval sampling done");

		// Second reset: factory values and detect enable loaded again
		@(posedge ref_clk);
		rst_n <= 1'b0;
		factory_trim <= 6'h11;
		cfg_det <= 1'b1;
		cycles(2);
		chk({2'h0, rc_trim_value}, {2'h0, ost_pkg::TRIM_MIDPOINT});
		chk({7'h00, in_system_programming}, 8'h00);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		cycles(3);
		chk({2'h0, rc_trim_value}, 8'h11);
		reg_rd(ost_pkg::OFF_PWR_MON, 1'b1, rd_val);
		chk(rd_val, 8'h80);
		chk({5'h00, comparator_enable, hysteresis_enable, slow_rc_enable}, 8'h06);
		$display("test second reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
